/* File: logic/scc_defs.svh */
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// Frame lengths in clock cycles.
`define SCC_SHORT_BITS      16
`define SCC_LONG_BITS       32

// Field positions of a frame, bit 0 travels first.
`define SCC_ADDR_MSB        6
`define SCC_ADDR_LSB        0
`define SCC_WR_BIT          7
`define SCC_DATA_MSB        15
`define SCC_DATA_LSB        8

// Addresses of the commands that this block inspects.
`define SCC_ADDR_MODE_CTRL  7'h01
`define SCC_ADDR_WATCHDOG_CONTROL_REG    7'h02
`define SCC_ADDR_WAKE_CTRL  7'h04
`define SCC_ADDR_GPIO_CTRL  7'h0b
`define SCC_ADDR_TIMER_CTRL 7'h0c
`define SCC_ADDR_DEV_STAT   7'h43
`define SCC_CTRL_LAST       7'h1e
`define SCC_SWK_FIRST       7'h20
`define SCC_SWK_LAST        7'h3f

// Field positions inside a data byte.
`define SCC_MODE_REQ_MSB    7
`define SCC_MODE_REQ_LSB    6
`define SCC_MEAS_BIT        5
`define SCC_TMR_ON_MSB      7
`define SCC_TMR_ON_LSB      4
`define SCC_TMR_PER_MSB     3
`define SCC_TMR_PER_LSB     0

// Reset values.
`define SCC_RST_REJECT      1'b0
`define SCC_RST_ERR         1'b0

`endif

/* File: logic/scc_pkg.sv */
`default_nettype none

package scc_pkg;

  typedef enum logic [2:0]
  {
    SCC_INIT      = 3'h0,
    SCC_NORMAL    = 3'h1,
    SCC_STOP      = 3'h2,
    SCC_SLEEP     = 3'h3,
    SCC_RESTART   = 3'h4,
    SCC_FAIL_SAFE = 3'h5
  } scc_mode_t;

  typedef enum logic [1:0]
  {
    SCC_REQ_NORMAL = 2'h0,
    SCC_REQ_SLEEP  = 2'h1,
    SCC_REQ_STOP   = 2'h2,
    SCC_REQ_SOFT   = 2'h3
  } scc_req_t;

endpackage

`default_nettype wire

/* File: logic/scc_spi_slave.sv */

`default_nettype none

`include "scc_defs.svh"

module scc_spi_slave
#(
  parameter int SHORT_BITS = `SCC_SHORT_BITS,
  parameter int LONG_BITS  = `SCC_LONG_BITS
)
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              spi_clk,
  input  wire logic              select_low_input,
  input  wire logic              spi_data_in,
  output logic                   spi_data_out,
  output logic                   spi_data_oe_low,
  input  wire logic              system_reset_output_low,
  input  wire logic [6:0]        rsp_status,
  input  wire logic [7:0]        rsp_data,
  input  wire logic [15:0]       rsp_ext,
  input  wire logic              bus_wake_enable,
  input  wire logic [7:0]        wake_pin_enable_control,
  input  wire logic              gpio_wake_enable,
  input  wire logic              gpio_configured,
  input  wire logic              fail_output,
  input  wire logic              wake_pin_measure_enable,
  input  wire logic [7:0]        wake_source_status_a,
  input  wire logic [7:0]        wake_source_status_b,
  input  wire logic              timer_wake_only,
  input  wire logic              timer_off,
  input  wire logic              wake_event,
  input  wire logic              restart_done,
  input  wire logic              fail_safe_req,
  input  wire logic              fail_safe_exit,
  output logic                   cmd_reject,
  output logic                   frame_error,
  output scc_pkg::scc_mode_t     mode,
  output logic                   wr_strobe,
  output logic [6:0]             wr_addr,
  output logic [7:0]             wr_data,
  output logic                   clear_strobe,
  output logic                   soft_reset_req,
  output logic                   interrupt_output_low
);

  import scc_pkg::*;

  localparam int CW = $clog2(LONG_BITS + 2);
  localparam logic [CW-1:0] CNT_ZERO  = '0;
  localparam logic [CW-1:0] CNT_SHORT = CW'(SHORT_BITS);
  localparam logic [CW-1:0] CNT_LONG  = CW'(LONG_BITS);
  localparam logic [CW-1:0] CNT_SAT   = CW'(LONG_BITS + 1);

  if (SHORT_BITS != 16 || LONG_BITS != 2 * SHORT_BITS)
  begin : g_bad_width
    $error("Frame lengths must be 16 and 32 bits.");
  end

  // ****************************************************************
  // Link domain.
  // ****************************************************************
  // Counters clear while select is high, so nothing depends on clock
  // edges outside a frame.
  logic [CW-1:0]        bit_cnt_reg;
  logic [CW-1:0]        frame_cnt_reg;
  logic [LONG_BITS-1:0] rx_reg;
  logic [4:0]           out_idx_reg;
  logic [LONG_BITS-1:0] tx_word_reg;

  always_ff @(negedge spi_clk or posedge select_low_input)
  begin
    if (select_low_input)
      bit_cnt_reg <= CNT_ZERO;
    else if (bit_cnt_reg != CNT_SAT)
      bit_cnt_reg <= bit_cnt_reg + CW'(1);
  end

  // Kept past the select rise, which clears the running count at once.
  always_ff @(posedge select_low_input)
  begin
    frame_cnt_reg <= bit_cnt_reg;
  end

  always_ff @(negedge spi_clk)
  begin
    if (!select_low_input && bit_cnt_reg < CNT_LONG)
      rx_reg[bit_cnt_reg[4:0]] <= spi_data_in;
  end

  always_ff @(posedge spi_clk or posedge select_low_input)
  begin
    if (select_low_input)
      out_idx_reg <= 5'h00;
    else
      out_idx_reg <= out_idx_reg + 5'h01;
  end

  // The output bit is a selection from a word that stops changing two clock
  // cycles into the frame; it never sees the input line, so no chaining exists.
  logic spi_on_reg;
  wire  out_bit = tx_word_reg[out_idx_reg];
  assign spi_data_out    = !system_reset_output_low ? 1'b1 : out_bit;
  assign spi_data_oe_low = select_low_input
                           | (!spi_on_reg & system_reset_output_low);

  // ****************************************************************
  // Synchronisers.
  // ****************************************************************
  logic sel_s1_reg, sel_s2_reg, sel_s3_reg;
  logic clk_s1_reg, clk_s2_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sel_s3_reg <= 1'b1;
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
    end
    else
    begin
      sel_s1_reg <= select_low_input;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      clk_s1_reg <= spi_clk;
      clk_s2_reg <= clk_s1_reg;
    end
  end

  wire sel_fall = sel_s3_reg & ~sel_s2_reg;
  wire sel_rise = ~sel_s3_reg & sel_s2_reg;

  // ****************************************************************
  // Frame checks.
  // ****************************************************************
  logic      clk_edge_err_reg;
  logic      rst_overlap_reg;
  logic      err_reg;
  logic      reject_reg;
  scc_mode_t mode_reg;

  // Count and word are read only after select is seen high twice
  // over, by which time the link side has stopped moving them.
  wire cnt_zero  = frame_cnt_reg == CNT_ZERO;
  wire cnt_long  = frame_cnt_reg == CNT_LONG;
  wire cnt_ok    = cnt_zero | frame_cnt_reg == CNT_SHORT | cnt_long;
  wire clk_edge  = (sel_fall | sel_rise) & clk_s2_reg;
  wire frame_bad = !cnt_ok | clk_edge_err_reg | clk_edge | rst_overlap_reg;

  wire spi_on    = mode_reg == SCC_INIT | mode_reg == SCC_NORMAL
                   | mode_reg == SCC_STOP;
  wire eval      = sel_rise & spi_on & !frame_bad & !cnt_zero;

  wire stuck = cnt_long ? (&rx_reg | ~|rx_reg)
                        : (&rx_reg[SHORT_BITS-1:0] | ~|rx_reg[SHORT_BITS-1:0]);

  wire [6:0] addr = rx_reg[`SCC_ADDR_MSB:`SCC_ADDR_LSB];
  wire       wr   = rx_reg[`SCC_WR_BIT];
  wire [7:0] data = rx_reg[`SCC_DATA_MSB:`SCC_DATA_LSB];
  scc_req_t  req;
  assign req = scc_req_t'(data[`SCC_MODE_REQ_MSB:`SCC_MODE_REQ_LSB]);

  function automatic logic addr_used(input logic [6:0] a);
    addr_used = a <= `SCC_CTRL_LAST
                || (a >= `SCC_SWK_FIRST && a <= `SCC_SWK_LAST)
                || a == `SCC_ADDR_DEV_STAT || a[6];
  endfunction

  wire used      = addr_used(addr);
  wire is_status = addr[6];
  wire is_mode   = addr == `SCC_ADDR_MODE_CTRL;
  wire is_wd     = addr == `SCC_ADDR_WATCHDOG_CONTROL_REG;
  wire in_stop   = mode_reg == SCC_STOP;
  wire in_init   = mode_reg == SCC_INIT;
  wire any_wake  = bus_wake_enable | (|wake_pin_enable_control) | gpio_wake_enable;
  wire mode_wr   = wr & is_mode & !stuck;

  wire r_stop_sleep = mode_wr & in_stop & req == SCC_REQ_SLEEP;
  wire r_init_low   = mode_wr & in_init
                      & (req == SCC_REQ_STOP | req == SCC_REQ_SLEEP);
  wire r_wd_parity  = wr & is_wd & (^data);
  wire r_stop_other = wr & in_stop & used & !is_status & !is_wd & !is_mode;
  wire r_no_wake    = mode_wr & mode_reg == SCC_NORMAL
                      & req == SCC_REQ_SLEEP & !any_wake;
  wire r_meas       = wr & addr == `SCC_ADDR_WAKE_CTRL & data[`SCC_MEAS_BIT]
                      & (fail_output | gpio_configured);
  wire r_gpio       = wr & addr == `SCC_ADDR_GPIO_CTRL & wake_pin_measure_enable;
  wire r_timer      = wr & addr == `SCC_ADDR_TIMER_CTRL
                      & data[`SCC_TMR_ON_MSB:`SCC_TMR_ON_LSB]
                        >= data[`SCC_TMR_PER_MSB:`SCC_TMR_PER_LSB];

  // Only the Sleep-without-wake case keeps the rest of its command.
  wire r_block  = stuck | r_stop_sleep | r_init_low | r_wd_parity | r_stop_other
                  | r_meas | r_gpio | r_timer;
  wire r_any    = used & (r_block | r_no_wake);
  wire do_write = eval & wr & used & !is_status & !r_block
                  & !(in_stop & is_mode);
  wire do_clear = eval & wr & is_status & !stuck;
  wire clr_rej  = do_clear & addr == `SCC_ADDR_DEV_STAT;

  // ****************************************************************
  // Operating mode.
  // ****************************************************************
  function automatic scc_mode_t cmd_mode(input scc_mode_t m, input scc_req_t q,
                                         input logic wake_ok);
    cmd_mode = m;
    if (q == SCC_REQ_SOFT)
      cmd_mode = SCC_RESTART;
    else if (m == SCC_INIT)
      cmd_mode = SCC_NORMAL;
    else if (m == SCC_STOP)
      cmd_mode = q == SCC_REQ_SLEEP ? SCC_RESTART
               : q == SCC_REQ_NORMAL ? SCC_NORMAL : SCC_STOP;
    else if (q == SCC_REQ_SLEEP)
      cmd_mode = wake_ok ? SCC_SLEEP : SCC_RESTART;
    else
      cmd_mode = q == SCC_REQ_STOP ? SCC_STOP : SCC_NORMAL;
  endfunction

  scc_mode_t mode_next;
  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      SCC_INIT, SCC_NORMAL, SCC_STOP:
        if (eval & mode_wr)
          mode_next = cmd_mode(mode_reg, req, any_wake);
      SCC_SLEEP:
        if (wake_event | (timer_wake_only & timer_off))
          mode_next = SCC_RESTART;
      SCC_RESTART:
        if (restart_done)
          mode_next = SCC_NORMAL;
      SCC_FAIL_SAFE:
        if (fail_safe_exit)
          mode_next = SCC_RESTART;
      default:
        mode_next = SCC_RESTART;
    endcase
    if (fail_safe_req)
      mode_next = SCC_FAIL_SAFE;
  end

  wire enter_stop  = mode_next == SCC_STOP & !in_stop;
  wire wake_pend   = (|wake_source_status_a) | (|wake_source_status_b);
  wire soft_req    = eval & mode_wr & req == SCC_REQ_SOFT;

  // ****************************************************************
  // State registers.
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mode_reg         <= SCC_INIT;
      spi_on_reg       <= 1'b1;
      clk_edge_err_reg <= 1'b0;
      rst_overlap_reg  <= 1'b0;
    end
    else
    begin
      mode_reg         <= mode_next;
      spi_on_reg       <= mode_next == SCC_INIT | mode_next == SCC_NORMAL
                          | mode_next == SCC_STOP;
      clk_edge_err_reg <= sel_rise ? 1'b0 : (clk_edge_err_reg | (sel_fall & clk_s2_reg));
      rst_overlap_reg  <= sel_rise ? 1'b0
                        : (rst_overlap_reg | (!sel_s2_reg & !system_reset_output_low));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      err_reg    <= `SCC_RST_ERR;
      reject_reg <= `SCC_RST_REJECT;
    end
    else
    begin
      if (sel_rise)
        err_reg <= frame_bad;
      if (eval & r_any)
        reject_reg <= 1'b1;
      else if (clr_rej)
        reject_reg <= 1'b0;
    end
  end

  // The reply word follows its sources while the synchronised select is high,
  // so it stops moving for the link side two clock cycles into a frame.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      tx_word_reg <= '0;
    else if (sel_s2_reg & !sel_rise)
      tx_word_reg <= {rsp_ext, rsp_data, rsp_status, err_reg};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_strobe            <= 1'b0;
      wr_addr              <= 7'h00;
      wr_data              <= 8'h00;
      clear_strobe         <= 1'b0;
      soft_reset_req       <= 1'b0;
      interrupt_output_low <= 1'b1;
    end
    else
    begin
      wr_strobe            <= do_write;
      wr_addr              <= do_write | do_clear ? addr : wr_addr;
      wr_data              <= do_write | do_clear ? data : wr_data;
      clear_strobe         <= do_clear;
      soft_reset_req       <= soft_req;
      interrupt_output_low <= !(enter_stop & wake_pend);
    end
  end

  assign cmd_reject  = reject_reg;
  assign frame_error = err_reg;
  assign mode        = mode_reg;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_reject_sticky: assert property (reject_reg & !clr_rej |=> reject_reg)
    else $error("Reject flag dropped without a clear.");
  a_stuck_reject: assert property (eval & stuck & used |=> reject_reg && !wr_strobe)
    else $error("Stuck frame not rejected.");
  a_count_error: assert property (sel_rise & !cnt_ok |=> err_reg && !wr_strobe)
    else $error("Bad clock count not flagged.");
  a_stop_sleep: assert property (eval & r_stop_sleep & !fail_safe_req
                                 |=> mode_reg == SCC_RESTART && reject_reg)
    else $error("Stop to Sleep not redirected.");
  a_init_normal: assert property (eval & r_init_low & !fail_safe_req
                                  |=> mode_reg == SCC_NORMAL && reject_reg)
    else $error("Init low-power request not redirected.");
  a_wd_parity: assert property (eval & r_wd_parity |=> !wr_strobe && reject_reg)
    else $error("Bad watchdog parity accepted.");
  a_stop_int: assert property (enter_stop & wake_pend
                               |=> !interrupt_output_low ##1 interrupt_output_low)
    else $error("Interrupt pulse missing on Stop entry.");
  a_unused_quiet: assert property (eval & !used & !reject_reg |=> !reject_reg)
    else $error("Unused address raised reject.");
  a_timer_wake: assert property (mode_reg == SCC_SLEEP & timer_wake_only & timer_off
                                 & !fail_safe_req |=> mode_reg == SCC_RESTART)
    else $error("Sleep did not wake on idle timer.");
  a_off_silent: assert property (!spi_on |=> !wr_strobe [*2])
    else $error("Write while interface disabled.");
  a_timer_bad: assert property (eval & r_timer |=> reject_reg && !wr_strobe)
    else $error("Bad timer setting accepted.");

  c_short_write: cover property (eval & !cnt_long & do_write);
  c_long_frame:  cover property (eval & cnt_long);
  c_zero_frame:  cover property (sel_rise & cnt_zero & !frame_bad);
  c_reject:      cover property (eval & r_any ##1 reject_reg);

endmodule

`default_nettype wire

/* File: bench/scc_host_model.sv */
`default_nettype none

module scc_host_model
(
  output logic      spi_clk,
  output logic      select_low_input,
  output logic      spi_data_in,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    spi_clk = 1'b0;
    select_low_input = 1'b1;
    spi_data_in = 1'b0;
  end

  // The clock only runs inside a frame, 15 ns per bit, bit 0 first.
  task automatic frame(input int n, input logic [31:0] w, output logic [31:0] rx);
    rx = '0;
    #3.1;
    select_low_input = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #1;
      spi_data_in = w[i];
      #6.5;
      rx[i] = sdo;
      spi_clk = 1'b1;
      #7.5;
      spi_clk = 1'b0;
    end
    if (n == 0)
    begin
      #7.5;
      rx[0] = sdo;
    end
    #7.5;
    select_low_input = 1'b1;
    // The data line no longer holds the last bit once the frame is over.
    spi_data_in = ~spi_data_in;
  endtask
endmodule

`default_nettype wire

/* File: bench/scc_spi_slave_tb.sv */
`default_nettype none

module scc_spi_slave_tb;
  import scc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        sys_rst_low = 1'b1;
  logic [6:0]  rsp_status = 7'h33;
  logic [7:0]  rsp_data = 8'h5a;
  logic [15:0] rsp_ext = 16'hc3a5;
  logic        bus_wk = 1'b0;
  logic [7:0]  pin_wk = 8'h00;
  logic        fo = 1'b0;
  logic        gc = 1'b0;
  logic        me = 1'b0;
  logic [7:0]  st_a = 8'h00;
  logic [7:0]  st_b = 8'h00;
  logic        tw = 1'b0;
  logic        toff = 1'b0;
  logic        fs = 1'b0;
  logic        tie0 = 1'b0;
  wire logic   spi_clk;
  wire logic   sel_low;
  wire logic   sdi;
  wire logic   sdo_d;
  wire logic   oe_low;
  wire logic   sdo;
  logic        sdo_float = 1'b0;
  logic        cmd_reject;
  logic        frame_error;
  logic        wr_strobe;
  logic        clear_strobe;
  logic        soft_req;
  logic        int_low;
  scc_mode_t   mode;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [31:0] rx;
  logic        st, cs, il, sr;
  int          oe_cnt = 0;
  int          mismatches = 0;
  int          n_compared = 0;

  always #2 sys_clk = ~sys_clk;

  // A released data line toggles so that a stale value can never match.
  assign sdo = oe_low ? sdo_float : sdo_d;
  always @(posedge sys_clk) sdo_float <= ~sdo_float;
  always @(posedge sys_clk) if (oe_low === 1'b0) oe_cnt <= oe_cnt + 1;

  scc_spi_slave scc_spi_slave_inst
  (
    .sys_clk                 (sys_clk),
    .reset                   (reset),
    .spi_clk                 (spi_clk),
    .select_low_input        (sel_low),
    .spi_data_in             (sdi),
    .spi_data_out            (sdo_d),
    .spi_data_oe_low         (oe_low),
    .system_reset_output_low (sys_rst_low),
    .rsp_status              (rsp_status),
    .rsp_data                (rsp_data),
    .rsp_ext                 (rsp_ext),
    .bus_wake_enable         (bus_wk),
    .wake_pin_enable_control (pin_wk),
    .gpio_wake_enable        (tie0),
    .gpio_configured         (gc),
    .fail_output             (fo),
    .wake_pin_measure_enable (me),
    .wake_source_status_a    (st_a),
    .wake_source_status_b    (st_b),
    .timer_wake_only         (tw),
    .timer_off               (toff),
    .wake_event              (tie0),
    .restart_done            (tie0),
    .fail_safe_req           (fs),
    .fail_safe_exit          (tie0),
    .cmd_reject              (cmd_reject),
    .frame_error             (frame_error),
    .mode                    (mode),
    .wr_strobe               (wr_strobe),
    .wr_addr                 (wr_addr),
    .wr_data                 (wr_data),
    .clear_strobe            (clear_strobe),
    .soft_reset_req          (soft_req),
    .interrupt_output_low    (int_low)
  );

  scc_host_model host_inst
  (
    .spi_clk          (spi_clk),
    .select_low_input (sel_low),
    .spi_data_in      (sdi),
    .sdo              (sdo)
  );

  // ******************************************************
  // Shared helpers
  // ******************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] wr(input logic [6:0] a, input logic [7:0] d);
    return {16'h0000, d, 1'b1, a};
  endfunction

  // Evaluation lands 2 cycles and its strobes 3 cycles after select rises; 10 cycles also keeps the gap.
  task automatic xfer(input int n, input logic [31:0] w);
    host_inst.frame(n, w, rx);
    {st, cs, il, sr} = 4'h0;
    repeat (10)
    begin
      @(posedge sys_clk);
      #1;
      {st, cs, il, sr} = {st, cs, il, sr} | {wr_strobe, clear_strobe, !int_low, soft_req};
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge sys_clk);
    reset <= 1'b1;
    {bus_wk, fo, gc, me, tw, toff} <= 6'h00;
    {pin_wk, st_a, st_b} <= 24'h000000;
    repeat (n) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic clr;
    xfer(16, wr(7'h43, 8'hff));
    chk("clear_strobe", 1, cs);
    chk("cmd_reject", 0, cmd_reject);
  endtask

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic s_write;
    xfer(16, wr(7'h1f, 8'h25));
    chk("cmd_reject", 0, cmd_reject);
    xfer(16, wr(7'h0c, 8'h25));
    chk("wr_strobe", 1, st);
    chk("wr_addr", 7'h0c, wr_addr);
    chk("wr_data", 8'h25, wr_data);
    chk("oe_low", 1, oe_low);
    chk("reply", {rsp_data, rsp_status, 1'b0}, rx);
    xfer(32, wr(7'h0c, 8'h13) | 32'hbeef0000);
    chk("reply32", {rsp_ext, rsp_data, rsp_status, 1'b0}, rx);
    chk("wr_data", 8'h13, wr_data);
  endtask

  task automatic s_rejects;
    logic [31:0] w [7];
    logic [2:0]  c [7];
    w = '{wr(7'h02, 8'h07), wr(7'h0c, 8'h55), 32'hffff, 32'h0,
          wr(7'h04, 8'h20), wr(7'h04, 8'h20), wr(7'h0b, 8'h01)};
    c = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge sys_clk);
      {fo, gc, me} <= c[i];
      xfer(16, w[i]);
      chk("wr_strobe", 0, st);
      chk("cmd_reject", 1, cmd_reject);
      clr();
    end
    @(posedge sys_clk);
    {fo, gc, me} <= 3'h0;
  endtask

  task automatic s_frame_err;
    xfer(8, wr(7'h0c, 8'h25));
    chk("wr_strobe", 0, st);
    chk("frame_error", 1, frame_error);
    xfer(0, 0);
    chk("err bit", 1, rx[0]);
    xfer(0, 0);
    chk("err bit", 0, rx[0]);
    @(posedge sys_clk);
    sys_rst_low <= 1'b0;
    xfer(16, wr(7'h0c, 8'h25));
    chk("sdo in reset", 32'hffff, rx);
    @(posedge sys_clk);
    sys_rst_low <= 1'b1;
    xfer(0, 0);
    chk("err bit", 1, rx[0]);
  endtask

  task automatic s_modes;
    int oe_base;
    do_reset(2);
    xfer(16, wr(7'h01, 8'h80));
    chk("mode", SCC_NORMAL, mode);
    chk("cmd_reject", 1, cmd_reject);
    clr();
    @(posedge sys_clk);
    st_b <= 8'h04;
    xfer(16, wr(7'h01, 8'h80));
    chk("mode", SCC_STOP, mode);
    chk("int pulse", 1, il);
    chk("cmd_reject", 0, cmd_reject);
    xfer(16, wr(7'h0c, 8'h25));
    chk("wr_strobe", 0, st);
    chk("cmd_reject", 1, cmd_reject);
    clr();
    xfer(16, wr(7'h01, 8'h05));
    chk("mode", SCC_NORMAL, mode);
    chk("wr_strobe", 0, st);
    xfer(16, wr(7'h01, 8'h80));
    xfer(16, wr(7'h01, 8'h40));
    chk("mode", SCC_RESTART, mode);
    chk("cmd_reject", 1, cmd_reject);
    oe_base = oe_cnt;
    xfer(16, wr(7'h01, 8'h00));
    chk("sdo driven", 0, oe_cnt - oe_base);
    chk("mode", SCC_RESTART, mode);
  endtask

  task automatic s_sleep;
    do_reset(2);
    xfer(16, wr(7'h01, 8'h00));
    xfer(16, wr(7'h01, 8'h40));
    chk("mode", SCC_RESTART, mode);
    chk("cmd_reject", 1, cmd_reject);
    chk("wr_strobe", 1, st);
    do_reset(2);
    xfer(16, wr(7'h01, 8'h00));
    @(posedge sys_clk);
    bus_wk <= 1'b1;
    pin_wk <= 8'h10;
    xfer(16, wr(7'h01, 8'h40));
    chk("mode", SCC_SLEEP, mode);
    @(posedge sys_clk);
    {tw, toff} <= 2'h3;
    repeat (10) @(posedge sys_clk);
    chk("mode", SCC_RESTART, mode);
    do_reset(2);
    xfer(16, wr(7'h01, 8'h00));
    xfer(16, wr(7'h01, 8'h80));
    xfer(16, wr(7'h01, 8'hc0));
    chk("soft reset", 1, sr);
    chk("cmd_reject", 0, cmd_reject);
  endtask

  task automatic s_fail_safe;
    int oe_base;
    do_reset(2);
    xfer(16, wr(7'h01, 8'h00));
    @(posedge sys_clk);
    fs <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("mode", SCC_FAIL_SAFE, mode);
    oe_base = oe_cnt;
    xfer(16, wr(7'h0c, 8'h25));
    chk("wr_strobe", 0, st);
    chk("sdo driven", 0, oe_cnt - oe_base);
    @(posedge sys_clk);
    fs <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    do_reset(20);
    xfer(16, wr(7'h01, 8'h00));
    chk("mode", SCC_NORMAL, mode);
    s_write();
    s_rejects();
    s_frame_err();
    s_modes();
    s_sleep();
    s_fail_safe();
    tally_and_finish();
  end

  // About 40 frames of under 550 ns each; 200 us leaves ample margin.
  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
